// ---- fpd_pkg.sv ----
package fpd_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_TYP_KHZ  = 3000;
  localparam int DT_UNIT_NS    = 50;
  localparam int DT_UNIT_CYC   = (DT_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // Serial frame
  // ----------------------------------------
  localparam int         FRAME_BITS    = 8;
  localparam logic [1:0] OP_DEADTIME   = 2'h1;
  localparam logic [7:0] CMD_SIMUL_ON  = 8'hC3;
  localparam logic [7:0] CMD_SIMUL_OFF = 8'hC0;
  localparam logic [5:0] DT_RESET      = 6'h04;

  // ----------------------------------------
  // Synchroniser bit positions
  // ----------------------------------------
  localparam int          SYNC_W   = 15;
  localparam int          IDX_CS   = 0;
  localparam int          IDX_SCLK = 1;
  localparam int          IDX_SI   = 2;
  localparam int          IDX_HSN  = 3;
  localparam int          IDX_LS   = 6;
  localparam int          IDX_EN   = 9;
  localparam int          IDX_SRC  = 11;
  localparam int          IDX_OC   = 14;
  localparam logic [14:0] SYNC_RST = 15'h003B;

  typedef struct packed {
    logic [2:0] hs;
    logic [2:0] ls;
  } fpd_gate_s;

  typedef struct packed {
    logic       allow_both;
    logic [5:0] deadtime;
  } fpd_cfg_s;

endpackage : fpd_pkg

// ---- fpd_top.sv ----
`timescale 1ns/1ns
module fpd_top #(
  parameter int DT_CNT_W = 10
) (
  input  wire logic              CLK_SYS,
  input  wire logic              RST,
  input  wire logic              DRIVE_ENABLE_ONE,
  input  wire logic              DRIVE_ENABLE_TWO,
  input  wire logic              PHASE_A_HIGH_CMD_N,
  input  wire logic              PHASE_B_HIGH_CMD_N,
  input  wire logic              PHASE_C_HIGH_CMD_N,
  input  wire logic              PHASE_A_LOW_CMD,
  input  wire logic              PHASE_B_LOW_CMD,
  input  wire logic              PHASE_C_LOW_CMD,
  input  wire logic              PHASE_A_HIGH_SOURCE,
  input  wire logic              PHASE_B_HIGH_SOURCE,
  input  wire logic              PHASE_C_HIGH_SOURCE,
  input  wire logic              OVERCURRENT_TRIP,
  input  wire logic              SPI_CS_N,
  input  wire logic              SPI_SCLK,
  input  wire logic              SPI_SI,
  output logic                   SPI_SO_O,
  output logic                   SPI_SO_OE,
  output fpd_pkg::fpd_gate_s     GATE,
  output logic                   PHASE_A_LEVEL_OUT,
  output logic                   PHASE_B_LEVEL_OUT,
  output logic                   PHASE_C_LEVEL_OUT,
  output logic                   OVERCURRENT_FLAG_OUT,
  output logic                   INT_OUT,
  output fpd_pkg::fpd_cfg_s      CFG
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [fpd_pkg::SYNC_W-1:0] raw;
  logic [fpd_pkg::SYNC_W-1:0] s1_q;
  logic [fpd_pkg::SYNC_W-1:0] s2_q;
  logic [fpd_pkg::SYNC_W-1:0] s3_q;
  logic [fpd_pkg::SYNC_W-1:0] cln_q;
  logic [fpd_pkg::SYNC_W-1:0] cln_d;

  assign raw = {OVERCURRENT_TRIP,
                PHASE_C_HIGH_SOURCE, PHASE_B_HIGH_SOURCE, PHASE_A_HIGH_SOURCE,
                DRIVE_ENABLE_TWO, DRIVE_ENABLE_ONE,
                PHASE_C_LOW_CMD, PHASE_B_LOW_CMD, PHASE_A_LOW_CMD,
                PHASE_C_HIGH_CMD_N, PHASE_B_HIGH_CMD_N, PHASE_A_HIGH_CMD_N,
                SPI_SI, SPI_SCLK, SPI_CS_N};

  // A bit moves only once stages two and three agree
  assign cln_d = (s2_q & s3_q) | (cln_q & (s2_q | s3_q));

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      s1_q  <= fpd_pkg::SYNC_RST;
      s2_q  <= fpd_pkg::SYNC_RST;
      s3_q  <= fpd_pkg::SYNC_RST;
      cln_q <= fpd_pkg::SYNC_RST;
    end
    else
    begin
      s1_q  <= raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      cln_q <= cln_d;
    end
  end

  wire       cs_n_c   = cln_q[fpd_pkg::IDX_CS];
  wire       sclk_c   = cln_q[fpd_pkg::IDX_SCLK];
  wire       si_c     = cln_q[fpd_pkg::IDX_SI];
  wire [2:0] hs_n_c   = cln_q[fpd_pkg::IDX_HSN +: 3];
  wire [2:0] ls_c     = cln_q[fpd_pkg::IDX_LS +: 3];
  wire [1:0] en_c     = cln_q[fpd_pkg::IDX_EN +: 2];
  wire [2:0] src_c    = cln_q[fpd_pkg::IDX_SRC +: 3];
  wire       oc_c     = cln_q[fpd_pkg::IDX_OC];
  wire       en_all   = en_c[0] & en_c[1];

  // ----------------------------------------
  // Serial port edges
  // ----------------------------------------
  logic sclk_prev_q;
  logic cs_prev_q;

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      sclk_prev_q <= 1'b1;
      cs_prev_q   <= 1'b1;
    end
    else
    begin
      sclk_prev_q <= sclk_c;
      cs_prev_q   <= cs_n_c;
    end
  end

  wire sel       = ~cs_n_c;
  wire sclk_fall = sel & sclk_prev_q & ~sclk_c;
  wire sclk_rise = sel & ~sclk_prev_q & sclk_c;
  wire cs_fall   = cs_prev_q & ~cs_n_c;
  wire cs_rise   = ~cs_prev_q & cs_n_c;

  // ----------------------------------------
  // Shift registers and frame commit
  // ----------------------------------------
  logic [7:0]        rx_q;
  logic [7:0]        tx_q;
  logic [3:0]        bits_q;
  fpd_pkg::fpd_cfg_s cfg_q;
  fpd_pkg::fpd_cfg_s cfg_d;
  logic              frame_err_q;
  logic              so_oe_q;

  wire frame_ok  = cs_rise & (bits_q == 4'(fpd_pkg::FRAME_BITS));
  wire frame_bad = cs_rise & (bits_q != 4'(fpd_pkg::FRAME_BITS));
  wire op_dt     = rx_q[7:6] == fpd_pkg::OP_DEADTIME;
  wire op_on     = rx_q == fpd_pkg::CMD_SIMUL_ON;
  wire op_off    = rx_q == fpd_pkg::CMD_SIMUL_OFF;

  always_comb
  begin
    cfg_d = cfg_q;
    if (frame_ok && op_dt)
      cfg_d.deadtime = rx_q[5:0];
    if (frame_ok && op_on)
      cfg_d.allow_both = 1'b1;
    if (frame_ok && op_off)
      cfg_d.allow_both = 1'b0;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      rx_q        <= 8'h00;
      tx_q        <= 8'h00;
      bits_q      <= 4'h0;
      cfg_q       <= '{allow_both: 1'b0, deadtime: fpd_pkg::DT_RESET};
      frame_err_q <= 1'b0;
      so_oe_q     <= 1'b0;
    end
    else
    begin
      so_oe_q <= sel;
      cfg_q   <= cfg_d;
      if (cs_fall)
      begin
        bits_q <= 4'h0;
        tx_q   <= {cfg_q.allow_both, oc_c, cfg_q.deadtime};
      end
      else
      begin
        if (sclk_fall)
        begin
          rx_q <= {rx_q[6:0], si_c};
          if (bits_q != 4'hF)
            bits_q <= bits_q + 4'h1;
        end
        if (sclk_rise)
          tx_q <= {tx_q[6:0], 1'b0};
      end
      if (frame_bad)
        frame_err_q <= 1'b1;
      else if (frame_ok)
        frame_err_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Gate drive with interlock and deadtime
  // ----------------------------------------
  fpd_pkg::fpd_gate_s gate_q;
  fpd_pkg::fpd_gate_s gate_d;
  logic [DT_CNT_W-1:0] dt_cnt_q [3];
  wire  [DT_CNT_W-1:0] dt_load = DT_CNT_W'(cfg_q.deadtime * fpd_pkg::DT_UNIT_CYC);

  for (genvar i = 0; i < 3; i++)
  begin : g_phase
    wire want_hs = en_all & ~hs_n_c[i];
    wire want_ls = en_all & ls_c[i];
    wire clash   = want_hs & want_ls & ~cfg_q.allow_both;
    wire dt_done = (dt_cnt_q[i] == '0) | cfg_q.allow_both;
    wire free_hs = ~gate_q.ls[i] | cfg_q.allow_both;
    wire free_ls = ~gate_q.hs[i] | cfg_q.allow_both;

    assign gate_d.hs[i] = want_hs & ~clash & (gate_q.hs[i] | (free_hs & dt_done));
    assign gate_d.ls[i] = want_ls & ~clash & (gate_q.ls[i] | (free_ls & dt_done));

    wire turn_off = (gate_q.hs[i] & ~gate_d.hs[i]) | (gate_q.ls[i] & ~gate_d.ls[i]);

    always_ff @(posedge CLK_SYS)
    begin
      if (RST)
        dt_cnt_q[i] <= '0;
      else if (turn_off)
        dt_cnt_q[i] <= dt_load;
      else if (dt_cnt_q[i] != '0)
        dt_cnt_q[i] <= dt_cnt_q[i] - DT_CNT_W'(1);
    end
  end

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  logic [2:0] lvl_q;
  logic       oc_q;
  logic       int_q;

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      gate_q <= '0;
      lvl_q  <= 3'h0;
      oc_q   <= 1'b0;
      int_q  <= 1'b0;
    end
    else
    begin
      gate_q <= gate_d;
      lvl_q  <= src_c;
      oc_q   <= oc_c;
      int_q  <= oc_c | frame_err_q;
    end
  end

  assign GATE                 = gate_q;
  assign PHASE_A_LEVEL_OUT    = lvl_q[0];
  assign PHASE_B_LEVEL_OUT    = lvl_q[1];
  assign PHASE_C_LEVEL_OUT    = lvl_q[2];
  assign OVERCURRENT_FLAG_OUT = oc_q;
  assign INT_OUT              = int_q;
  assign SPI_SO_O             = tx_q[7] & so_oe_q;
  assign SPI_SO_OE            = so_oe_q;
  assign CFG                  = cfg_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  property p_enable_and;
    !en_all |=> (gate_q == '0);
  endproperty
  a_enable_and: assert property (p_enable_and) else $error("gate on while disabled");

  property p_hs_polarity;
    $rose(gate_q.hs[0]) |-> $past(!hs_n_c[0] && en_all);
  endproperty
  a_hs_polarity: assert property (p_hs_polarity) else $error("high side without low cmd");

  property p_ls_polarity;
    gate_q.ls[1] |-> $past(ls_c[1]);
  endproperty
  a_ls_polarity: assert property (p_ls_polarity) else $error("low side without high cmd");

  property p_shift;
    sclk_fall && !cs_fall |=> rx_q[0] == $past(si_c) && rx_q[7:1] == $past(rx_q[6:0]);
  endproperty
  a_shift: assert property (p_shift) else $error("serial bit not shifted in");

  property p_so_release;
    cs_n_c ##1 cs_n_c |-> !SPI_SO_OE;
  endproperty
  a_so_release: assert property (p_so_release) else $error("serial out driven unselected");

  property p_level;
    1'b1 |=> lvl_q == $past(src_c) && oc_q == $past(oc_c);
  endproperty
  a_level: assert property (p_level) else $error("status output wrong");

  property p_deadtime;
    $rose(gate_q.ls[2]) && !cfg_q.allow_both && $past(!cfg_q.allow_both)
      |-> $past(dt_cnt_q[2] == '0 && !gate_q.hs[2]);
  endproperty
  a_deadtime: assert property (p_deadtime) else $error("deadtime skipped");

  property p_no_overlap;
    !cfg_q.allow_both && $past(!cfg_q.allow_both) |-> (gate_q.hs & gate_q.ls) == 3'h0;
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("shoot-through");

  property p_partial;
    cs_rise && bits_q != 4'(fpd_pkg::FRAME_BITS) |=> $stable(cfg_q) ##1 frame_err_q;
  endproperty
  a_partial: assert property (p_partial) else $error("partial frame committed");

  property p_reset;
    @(posedge CLK_SYS) disable iff (1'b0)
      RST |=> gate_q == '0 && !INT_OUT && !SPI_SO_OE;
  endproperty
  a_reset: assert property (p_reset) else $error("reset did not clear");

endmodule : fpd_top

// ---- fpd_mcu_model.sv ----
`timescale 1ns/1ns
module fpd_mcu_model (
  output logic      cs_n,
  output logic      sclk,
  output logic      si,
  input  wire logic so_o,
  input  wire logic so_oe
);
  logic [7:0] rx;
  logic       oe_all;

  initial
  begin
    cs_n   = 1'b1;
    sclk   = 1'b1;
    si     = 1'b0;
    rx     = 8'h00;
    oe_all = 1'b0;
  end

  // ----------------------------------------
  // Frame; clock idles high, stands still between frames
  // ----------------------------------------
  task automatic xfer(input logic [7:0] tx, input int nbits);
    oe_all = 1'b1;
    cs_n   = 1'b0;
    // Odd offset keeps serial edges off the system clock's rising edge
    #102;
    for (int i = 7; i > 7 - nbits; i--)
    begin
      si = tx[i];
      #62;
      rx     = {rx[6:0], so_o};
      oe_all = oe_all & so_oe;
      sclk   = 1'b0;
      #63;
      sclk = 1'b1;
    end
    #62;
    si   = ~si;
    cs_n = 1'b1;
    #100;
  endtask : xfer
endmodule : fpd_mcu_model

// ---- tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  logic               clk;
  logic               rst;
  logic               en_one;
  logic               en_two;
  logic [2:0]         hi_n;
  logic [2:0]         lo;
  logic [2:0]         src;
  logic               oc_trip;
  wire logic          cs_n;
  wire logic          sclk;
  wire logic          si;
  logic               so_o;
  logic               so_oe;
  fpd_pkg::fpd_gate_s gate;
  logic [2:0]         lvl;
  logic               oc_flag;
  logic               int_out;
  fpd_pkg::fpd_cfg_s  cfg;
  int                 num_errors;
  int                 cmp_count;

  fpd_top i_fpd_top (.CLK_SYS(clk), .RST(rst), .DRIVE_ENABLE_ONE(en_one),
    .DRIVE_ENABLE_TWO(en_two), .PHASE_A_HIGH_CMD_N(hi_n[0]), .PHASE_B_HIGH_CMD_N(hi_n[1]),
    .PHASE_C_HIGH_CMD_N(hi_n[2]), .PHASE_A_LOW_CMD(lo[0]), .PHASE_B_LOW_CMD(lo[1]),
    .PHASE_C_LOW_CMD(lo[2]), .PHASE_A_HIGH_SOURCE(src[0]), .PHASE_B_HIGH_SOURCE(src[1]),
    .PHASE_C_HIGH_SOURCE(src[2]), .OVERCURRENT_TRIP(oc_trip), .SPI_CS_N(cs_n),
    .SPI_SCLK(sclk), .SPI_SI(si), .SPI_SO_O(so_o), .SPI_SO_OE(so_oe), .GATE(gate),
    .PHASE_A_LEVEL_OUT(lvl[0]), .PHASE_B_LEVEL_OUT(lvl[1]), .PHASE_C_LEVEL_OUT(lvl[2]),
    .OVERCURRENT_FLAG_OUT(oc_flag), .INT_OUT(int_out), .CFG(cfg));

  fpd_mcu_model i_mcu (.cs_n(cs_n), .sclk(sclk), .si(si), .so_o(so_o), .so_oe(so_oe));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic drv(input logic [2:0] h, input logic [2:0] l, input int w);
    @(negedge clk);
    hi_n = h;
    lo   = l;
    repeat (w) @(negedge clk);
  endtask : drv

  task automatic give_verdict;
    if (num_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_gates;
    for (int p = 0; p < 3; p++)
    begin
      drv(~(3'b001 << p), 3'b000, 40);
      check(8'(gate), 8'h08 << p);
      drv(3'b111, 3'b001 << p, 40);
      check(8'(gate), 8'h01 << p);
    end
    drv(3'b111, 3'b111, 40);
    for (int k = 0; k < 2; k++)
    begin
      {en_one, en_two} = (k == 0) ? 2'b01 : 2'b10;
      repeat (20) @(negedge clk);
      check(8'(gate), 8'h00);
    end
    {en_one, en_two} = 2'b11;
    repeat (40) @(negedge clk);
    check(8'(gate), 8'h07);
  endtask : t_gates

  task automatic t_deadtime;
    int n;
    i_mcu.xfer({2'b01, 6'h02}, 8);
    check(8'(cfg), 8'h02);
    drv(3'b110, 3'b000, 40);
    drv(3'b111, 3'b001, 0);
    n = 0;
    while (gate.hs[0] !== 1'b0 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 50)
    begin
      num_errors++;
      give_verdict();
    end
    n = 0;
    while (gate.ls[0] !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 200)
    begin
      num_errors++;
      give_verdict();
    end
    // Gap may include the one spare off cycle
    check(8'(n >= 2 * fpd_pkg::DT_UNIT_CYC && n <= 2 * fpd_pkg::DT_UNIT_CYC + 2), 8'h01);
  endtask : t_deadtime

  task automatic t_simul;
    drv(3'b110, 3'b001, 40);
    check(8'(gate), 8'h00);
    i_mcu.xfer(fpd_pkg::CMD_SIMUL_ON, 8);
    repeat (40) @(negedge clk);
    check(8'(cfg), 8'h42);
    check(8'(gate), 8'h09);
    i_mcu.xfer(fpd_pkg::CMD_SIMUL_OFF, 8);
    repeat (40) @(negedge clk);
    check(8'(gate), 8'h00);
    drv(3'b111, 3'b000, 40);
  endtask : t_simul

  task automatic t_partial;
    i_mcu.xfer(8'h4F, 5);
    check(8'(cfg), 8'h02);
    check(8'(int_out), 8'h01);
    i_mcu.xfer({2'b01, 6'h05}, 8);
    check(8'(cfg), 8'h05);
    check(8'(int_out), 8'h00);
  endtask : t_partial

  task automatic t_status;
    for (int p = 0; p < 3; p++)
    begin
      src = 3'b001 << p;
      repeat (20) @(negedge clk);
      check(8'(lvl), 8'h01 << p);
    end
    oc_trip = 1'b1;
    repeat (20) @(negedge clk);
    check(8'(oc_flag), 8'h01);
    check(8'(int_out), 8'h01);
    check(8'(so_oe), 8'h00);
    // Unknown code: status readback only, no config change
    i_mcu.xfer(8'hFF, 8);
    check(i_mcu.rx, 8'h45);
    check(8'(i_mcu.oe_all), 8'h01);
    check(8'(cfg), 8'h05);
    @(negedge clk);
    oc_trip = 1'b0;
    repeat (20) @(negedge clk);
    check(8'(oc_flag), 8'h00);
    check(8'(int_out), 8'h00);
  endtask : t_status

  task automatic t_reset;
    drv(3'b111, 3'b111, 40);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    check(8'(gate), 8'h00);
    check(8'(cfg), 8'(fpd_pkg::DT_RESET));
    rst = 1'b0;
    repeat (40) @(negedge clk);
    check(8'(gate), 8'h07);
  endtask : t_reset

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #900000;
    num_errors++;
    give_verdict();
  end

  initial
  begin
    num_errors = 0;
    cmp_count  = 0;
    rst        = 1'b1;
    {en_one, en_two} = 2'b11;
    hi_n       = 3'b111;
    lo         = 3'b000;
    src        = 3'b000;
    oc_trip    = 1'b0;
    repeat (12) @(negedge clk);
    check(8'(gate), 8'h00);
    check(8'(cfg), 8'(fpd_pkg::DT_RESET));
    rst = 1'b0;
    repeat (10) @(negedge clk);
    check(8'(so_oe), 8'h00);
    t_gates();
    t_deadtime();
    t_simul();
    t_partial();
    t_status();
    t_reset();
    give_verdict();
  end
endmodule : tb_top
